// ===== link_rx_model.sv
// Receiver-side model of the lane partner: owns the sync request pin.
// Assumes the bench calls setReq just after a falling clock edge.
`timescale 1ns/1ps
module link_rx_model
(
	// Clock
	input wire logic clk_sys,
	// Lane from the transmitter
	input wire logic [7:0] linkOctet,
	input wire logic linkIsK,
	// Sync request back to the transmitter, active low
	output logic syncReq_n
);
	// Idle high: the receiver only asks for sync when told to
	initial syncReq_n = 1'b1;

	// Drive or release the request; the pin is actively driven both ways
	task automatic setReq(input logic lvl);
		syncReq_n = lvl;
	endtask
endmodule

// ===== link_test_consts.svh
// Constants for the serial link test pattern generator.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef LINK_TEST_CONSTS_SVH
`define LINK_TEST_CONSTS_SVH

// ----------------------------------------------------------------
// Control and data characters, as octets fed to the encoder
// ----------------------------------------------------------------
`define CHAR_K285 8'hbc
`define CHAR_D215 8'hb5
`define CHAR_K280 8'h1c
`define CHAR_K283 8'h7c
`define CHAR_K284 8'h9c

// ----------------------------------------------------------------
// Modified random pattern, twelve octets
// ----------------------------------------------------------------
`define RPAT_LEN 4'd12
`define RPAT_LAST 4'd11
`define RPAT_0 8'hbe
`define RPAT_1 8'hd7
`define RPAT_2 8'h23
`define RPAT_3 8'h47
`define RPAT_4 8'h6b
`define RPAT_5 8'h8f
`define RPAT_6 8'hb3
`define RPAT_7 8'h14
`define RPAT_8 8'h5e
`define RPAT_9 8'hfb
`define RPAT_10 8'h35
`define RPAT_11 8'h59

// ----------------------------------------------------------------
// Lane alignment sequence shape
// ----------------------------------------------------------------
`define ILA_MF_LAST 8'd31
`define ILA_MF_COUNT_LAST 2'd3
`define ILA_CFG_MF 2'd1

// ----------------------------------------------------------------
// Link modes that carry a short transport pattern
// ----------------------------------------------------------------
`define LMODE_14 5'd14
`define LMODE_15 5'd15
`define NUM_CONV 8
`define SAMPLE_TOP 4'hf
`endif

// ===== link_test_pkg.sv
// Types shared by the serial link test pattern generator.
// Assumes the constants header is compiled alongside.
package link_test_pkg;

	// Selected test pattern; one at a time
	typedef enum logic [2:0]
	{
		MODE_NORMAL,
		MODE_TRANSPORT,
		MODE_D215,
		MODE_K285,
		MODE_RILA,
		MODE_RPAT
	} testMode_t;

	// Device variant, sets which converter slots exist
	typedef enum logic [1:0]
	{
		VAR_SINGLE,
		VAR_DUAL,
		VAR_QUAD
	} variant_t;

endpackage

// ===== pattern_if.sv
// Carrier between the generator core and its pattern table.
// Assumes both ends run on the same clock; the table is combinational.
`timescale 1ns/1ps
interface pattern_if;
	logic [3:0] rpatIdx;
	logic [7:0] rpatOctet;
	logic sampleSel;
	logic [4:0] linkMode;
	link_test_pkg::variant_t variant;
	logic [11:0] sampleVal [8];
	logic [7:0] slotMask;

	modport table_end
	(
		input rpatIdx,
		input sampleSel,
		input linkMode,
		input variant,
		output rpatOctet,
		output sampleVal,
		output slotMask
	);
	modport core_end
	(
		output rpatIdx,
		output sampleSel,
		output linkMode,
		output variant,
		input rpatOctet,
		input sampleVal,
		input slotMask
	);
endinterface

// ===== pattern_table.sv
// Combinational table of the random pattern and transport samples.
// Assumes the caller registers its outputs.
`timescale 1ns/1ps
`include "link_test_consts.svh"
module pattern_table
(
	// Link to the core
	pattern_if.table_end pat
);

	// ------------------------------------------------------------
	// Slot presence per link mode and variant
	// ------------------------------------------------------------
	function automatic logic slotOn(input logic [4:0] lm,
		input link_test_pkg::variant_t v, input int n);
		logic on;
		on = 1'b0;
		if (lm == `LMODE_14)
		begin
			// Two slots always, four on dual/quad, eight on quad
			on = (n < 2) || (n < 4 && v != link_test_pkg::VAR_SINGLE)
				|| (v == link_test_pkg::VAR_QUAD);
		end
		else if (lm == `LMODE_15)
		begin
			on = (n < 4) || (v == link_test_pkg::VAR_DUAL);
		end
		return on;
	endfunction

	// ------------------------------------------------------------
	// Per-converter sample: top nibble counts down, middle is index
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `NUM_CONV; g++)
		begin : gSlot
			logic [3:0] idx;
			assign idx = 4'(g);
			assign pat.slotMask[g] = slotOn(pat.linkMode, pat.variant, g);
			// Sample 1 then sample 2; a sum in the concatenation would wrap
			assign pat.sampleVal[g] = pat.slotMask[g] ?
				{`SAMPLE_TOP - idx, idx, pat.sampleSel ? 4'h2 : 4'h1} :
				12'h000;
		end
	endgenerate

	// Random pattern octet in encoder input order
	always_comb
	begin
		case (pat.rpatIdx)
			4'd0: pat.rpatOctet = `RPAT_0;
			4'd1: pat.rpatOctet = `RPAT_1;
			4'd2: pat.rpatOctet = `RPAT_2;
			4'd3: pat.rpatOctet = `RPAT_3;
			4'd4: pat.rpatOctet = `RPAT_4;
			4'd5: pat.rpatOctet = `RPAT_5;
			4'd6: pat.rpatOctet = `RPAT_6;
			4'd7: pat.rpatOctet = `RPAT_7;
			4'd8: pat.rpatOctet = `RPAT_8;
			4'd9: pat.rpatOctet = `RPAT_9;
			4'd10: pat.rpatOctet = `RPAT_10;
			4'd11: pat.rpatOctet = `RPAT_11;
			default: pat.rpatOctet = `RPAT_0;
		endcase
	end

endmodule

// ===== serial_link_test_pattern_gen.sv
// Test pattern generator on the transmit side of the serial data link.
// Assumes the receiver's sync request arrives asynchronously on a pin
// and that the encoder downstream takes one octet plus a control flag.
//
// Summary of operation
// - D21.5 mode sends unbroken D21.5 octets on the lane.
// - D21.5 mode works with either line encoding.
// - K28.5 mode sends unbroken K28.5; only with 8B/10B encoding.
// - Repeated ILA mode never enters data phase; repeats alignment.
// - Each sync request in repeated ILA mode restarts code group sync.
// - After sync, alignment sequences follow back to back indefinitely.
// - Random pattern mode repeats twelve octets; only with 8B/10B.
// - Random pattern octets are BE D7 23 47 6B 8F B3 14 5E FB 35 59.
// - Link mode 14 sends two 12-bit samples per converter slot.
// - Mode 14 slots 2-3 on dual/quad only, 4-7 on quad only.
// - Mode 15 uses same samples; slots 4-7 on dual only.
`timescale 1ns/1ps
`include "link_test_consts.svh"
module serial_link_test_pattern_gen
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Configuration, same clock domain
	input wire link_test_pkg::testMode_t testMode,
	input wire logic [4:0] linkModeIndex,
	input wire link_test_pkg::variant_t variant,
	input wire logic encoding64b,
	// Receiver sync request pin, active low, asynchronous
	input wire logic syncReq_n,
	// Normal traffic
	input wire logic [11:0] convIn [8],
	input wire logic [7:0] linkOctetIn,
	input wire logic linkIsKIn,
	// Outgoing traffic
	output logic [11:0] convOut [8],
	output logic [7:0] linkOctet,
	output logic linkIsK,
	output logic patternActive
);

	typedef enum logic {ST_CGS, ST_ILA} ilaState_t;

	pattern_if pat();
	pattern_table uTable
	(
		.pat(pat.table_end)
	);

	// ------------------------------------------------------------
	// Sync request synchroniser
	// ------------------------------------------------------------
	logic syncMeta_r;
	logic syncReqSyn_n_r;
	// Two stages; only the second is looked at by logic
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncMeta_r <= 1'b1;
			syncReqSyn_n_r <= 1'b1;
		end
		else
		begin
			syncMeta_r <= syncReq_n;
			syncReqSyn_n_r <= syncMeta_r;
		end
	end

	// ------------------------------------------------------------
	// Mode qualification
	// ------------------------------------------------------------
	link_test_pkg::testMode_t modeEff;
	// 8B/10B-only patterns fall back to normal traffic under 64B/66B
	always_comb
	begin
		modeEff = testMode;
		if (encoding64b && (testMode == link_test_pkg::MODE_K285 ||
			testMode == link_test_pkg::MODE_RILA ||
			testMode == link_test_pkg::MODE_RPAT))
		begin
			modeEff = link_test_pkg::MODE_NORMAL;
		end
	end

	logic rilaOn;
	logic rpatOn;
	logic transOn;
	assign rilaOn = (modeEff == link_test_pkg::MODE_RILA);
	assign rpatOn = (modeEff == link_test_pkg::MODE_RPAT);
	assign transOn = (modeEff == link_test_pkg::MODE_TRANSPORT);

	// ------------------------------------------------------------
	// Sequencing state: alignment, random pattern, sample phase
	// ------------------------------------------------------------
	ilaState_t ilaSt_r, ilaSt_nxt;
	logic [7:0] octCnt_r, octCnt_nxt;
	logic [1:0] mfCnt_r, mfCnt_nxt;
	logic [3:0] rpatIdx_r, rpatIdx_nxt;
	logic sampleSel_r, sampleSel_nxt;

	// Counters restart whenever their mode is left
	always_comb
	begin
		ilaSt_nxt = ST_CGS;
		octCnt_nxt = 8'h00;
		mfCnt_nxt = 2'h0;
		rpatIdx_nxt = 4'h0;
		sampleSel_nxt = 1'b0;
		if (rilaOn && syncReqSyn_n_r)
		begin
			case (ilaSt_r)
				ST_CGS: ilaSt_nxt = ST_ILA;
				ST_ILA:
				begin
					// Wrap into a new sequence, never into data
					ilaSt_nxt = ST_ILA;
					octCnt_nxt = (octCnt_r == `ILA_MF_LAST) ? 8'h00 :
						octCnt_r + 8'h01;
					mfCnt_nxt = (octCnt_r == `ILA_MF_LAST) ?
						mfCnt_r + 2'h1 : mfCnt_r;
				end
				default: ilaSt_nxt = ST_CGS;
			endcase
		end
		if (rpatOn)
		begin
			rpatIdx_nxt = (rpatIdx_r == `RPAT_LAST) ? 4'h0 :
				rpatIdx_r + 4'h1;
		end
		if (transOn)
		begin
			sampleSel_nxt = ~sampleSel_r;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ilaSt_r <= ST_CGS;
			octCnt_r <= 8'h00;
			mfCnt_r <= 2'h0;
			rpatIdx_r <= 4'h0;
			sampleSel_r <= 1'b0;
		end
		else
		begin
			ilaSt_r <= ilaSt_nxt;
			octCnt_r <= octCnt_nxt;
			mfCnt_r <= mfCnt_nxt;
			rpatIdx_r <= rpatIdx_nxt;
			sampleSel_r <= sampleSel_nxt;
		end
	end

	assign pat.rpatIdx = rpatIdx_r;
	assign pat.sampleSel = sampleSel_r;
	assign pat.linkMode = linkModeIndex;
	assign pat.variant = variant;

	// ------------------------------------------------------------
	// Output selection
	// ------------------------------------------------------------
	logic [11:0] convOut_r [8];
	logic [11:0] convOut_nxt [8];
	logic [7:0] linkOctet_r, linkOctet_nxt;
	logic linkIsK_r, linkIsK_nxt;
	logic active_r, active_nxt;

	// Pattern replaces traffic only while a mode is active
	always_comb
	begin
		convOut_nxt = convIn;
		linkOctet_nxt = linkOctetIn;
		linkIsK_nxt = linkIsKIn;
		active_nxt = (modeEff != link_test_pkg::MODE_NORMAL);
		case (modeEff)
			link_test_pkg::MODE_TRANSPORT: convOut_nxt = pat.sampleVal;
			link_test_pkg::MODE_D215:
			begin
				linkOctet_nxt = `CHAR_D215;
				linkIsK_nxt = 1'b0;
			end
			link_test_pkg::MODE_K285:
			begin
				linkOctet_nxt = `CHAR_K285;
				linkIsK_nxt = 1'b1;
			end
			link_test_pkg::MODE_RPAT:
			begin
				linkOctet_nxt = pat.rpatOctet;
				linkIsK_nxt = 1'b0;
			end
			link_test_pkg::MODE_RILA:
			begin
				linkIsK_nxt = 1'b1;
				if (!syncReqSyn_n_r || ilaSt_r == ST_CGS)
					linkOctet_nxt = `CHAR_K285;
				else if (octCnt_r == 8'h00)
					linkOctet_nxt = `CHAR_K280;
				else if (octCnt_r == `ILA_MF_LAST)
					linkOctet_nxt = `CHAR_K283;
				else if (mfCnt_r == `ILA_CFG_MF && octCnt_r == 8'h01)
					linkOctet_nxt = `CHAR_K284;
				else
				begin
					// Filler carries the octet position as data
					linkOctet_nxt = octCnt_r;
					linkIsK_nxt = 1'b0;
				end
			end
			default: active_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			convOut_r <= '{default: 12'h000};
			linkOctet_r <= 8'h00;
			linkIsK_r <= 1'b0;
			active_r <= 1'b0;
		end
		else
		begin
			convOut_r <= convOut_nxt;
			linkOctet_r <= linkOctet_nxt;
			linkIsK_r <= linkIsK_nxt;
			active_r <= active_nxt;
		end
	end

	assign convOut = convOut_r;
	assign linkOctet = linkOctet_r;
	assign linkIsK = linkIsK_r;
	assign patternActive = active_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	wire syncHeld = syncReqSyn_n_r;

	sequence seqIlaEnd;
		rilaOn && syncHeld && ilaSt_r == ST_ILA && octCnt_r == `ILA_MF_LAST;
	endsequence
	sequence seqIlaWrap;
		seqIlaEnd ##1 (rilaOn && syncHeld);
	endsequence
	sequence seqRpatWrap;
		(rpatOn && rpatIdx_r == `RPAT_LAST) ##1 rpatOn;
	endsequence

	chk_d215_stream: assert property (
		modeEff == link_test_pkg::MODE_D215 |=>
		linkOctet == `CHAR_D215 && !linkIsK)
		else $error("D21.5 stream broken");
	chk_d215_any_enc: assert property (
		encoding64b && testMode == link_test_pkg::MODE_D215 |=>
		linkOctet == `CHAR_D215 && patternActive)
		else $error("D21.5 missing under 64b66b");
	chk_k285_only_8b: assert property (
		encoding64b && testMode == link_test_pkg::MODE_K285 |=>
		linkOctet == $past(linkOctetIn) && !patternActive)
		else $error("K28.5 sent under 64b66b");
	chk_ila_restart: assert property (
		rilaOn && !syncHeld |=> ilaSt_r == ST_CGS &&
		linkOctet == `CHAR_K285 && linkIsK)
		else $error("Sync request did not restart sync");
	chk_ila_end_mark: assert property (
		seqIlaEnd |=> linkOctet == `CHAR_K283 && linkIsK)
		else $error("Alignment sequence did not end");
	chk_ila_back2back: assert property (
		seqIlaWrap |=> linkOctet == `CHAR_K280 && linkIsK)
		else $error("Alignment sequence not repeated");
	chk_rpat_start: assert property (
		rpatOn && rpatIdx_r == 4'h0 ##1 rpatOn |=>
		$past(linkOctet) == `RPAT_0 && linkOctet == `RPAT_1)
		else $error("Random pattern start wrong");
	chk_rpat_wrap: assert property (
		seqRpatWrap |=> linkOctet == `RPAT_0 && $past(linkOctet) == `RPAT_11)
		else $error("Random pattern did not wrap at twelve");
	chk_mode14_slots: assert property (
		transOn && linkModeIndex == `LMODE_14 &&
		variant == link_test_pkg::VAR_SINGLE && !sampleSel_r |=>
		convOut[0] == 12'hf01 && convOut[1] == 12'he11 &&
		convOut[2] == 12'h000 ##1 (convOut[0] == 12'hf02 ||
		!$past(transOn && linkModeIndex == `LMODE_14)))
		else $error("Mode 14 samples wrong");
	chk_mode15_slots: assert property (
		transOn && linkModeIndex == `LMODE_15 &&
		variant == link_test_pkg::VAR_DUAL && sampleSel_r |=>
		convOut[7] == 12'h872 && convOut[3] == 12'hc32)
		else $error("Mode 15 samples wrong");
	chk_normal_pass: assert property (
		modeEff == link_test_pkg::MODE_NORMAL |=>
		convOut[5] == $past(convIn[5]) && !patternActive)
		else $error("Normal traffic not passed");

endmodule

// ===== serial_link_test_pattern_gen_bench.sv
// Self-checking bench for the serial link test pattern generator.
// Assumes one-cycle registered outputs and the receiver model beside it.
`timescale 1ns/1ps
module serial_link_test_pattern_gen_bench;
	logic clk_sys;
	logic arst_n;
	link_test_pkg::testMode_t testMode;
	logic [4:0] linkModeIndex;
	link_test_pkg::variant_t variant;
	logic encoding64b;
	logic syncReq_n;
	logic [11:0] convIn [8];
	logic [7:0] linkOctetIn;
	logic linkIsKIn;
	logic [11:0] convOut [8];
	logic [7:0] linkOctet;
	logic linkIsK;
	logic patternActive;
	int err_total = 0;
	int total_checks = 0;
	logic [15:0] lfsr = 16'h004a;
	logic [11:0] expIn [8];
	logic [7:0] expOct;
	logic expK;
	int rpat [$] = {'hbe, 'hd7, 'h23, 'h47, 'h6b, 'h8f, 'hb3, 'h14, 'h5e,
		'hfb, 'h35, 'h59};
	link_test_pkg::testMode_t only8b [3] = '{link_test_pkg::MODE_K285,
		link_test_pkg::MODE_RILA, link_test_pkg::MODE_RPAT};

	serial_link_test_pattern_gen DUT
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.testMode(testMode),
		.linkModeIndex(linkModeIndex),
		.variant(variant),
		.encoding64b(encoding64b),
		.syncReq_n(syncReq_n),
		.convIn(convIn),
		.linkOctetIn(linkOctetIn),
		.linkIsKIn(linkIsKIn),
		.convOut(convOut),
		.linkOctet(linkOctet),
		.linkIsK(linkIsK),
		.patternActive(patternActive)
	);

	link_rx_model rx
	(
		.clk_sys(clk_sys),
		.linkOctet(linkOctet),
		.linkIsK(linkIsK),
		.syncReq_n(syncReq_n)
	);

	// 200 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Reference model and helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] nextRand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Slot presence by link mode and variant; other link modes send zero
	function automatic logic [11:0] expSample(input int lm, input int v,
		input int n, input int s);
		bit on;
		on = (lm == 14) ? (n < 2 || (n < 4 && v != 0) || v == 2) :
			(lm == 15) ? (n < 4 || v == 1) : 1'b0;
		return on ? {4'(15 - n), 4'(n), 4'(s + 1)} : 12'h000;
	endfunction

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Fresh random traffic at the falling edge; outputs follow one edge on
	task automatic step();
		for (int i = 0; i < 8; i++)
		begin
			lfsr = nextRand(lfsr);
			convIn[i] = lfsr[11:0];
			expIn[i] = lfsr[11:0];
		end
		lfsr = nextRand(lfsr);
		linkOctetIn = lfsr[7:0];
		linkIsKIn = lfsr[8];
		expOct = lfsr[7:0];
		expK = lfsr[8];
		@(negedge clk_sys);
	endtask

	task automatic chkNormal();
		for (int i = 0; i < 8; i++)
			chk(convOut[i], expIn[i]);
		chk(linkOctet, expOct);
		chk(linkIsK, expK);
		chk(patternActive, 12'h000);
	endtask

	task automatic chkOct(input logic [7:0] o, input logic k);
		chk(linkOctet, o);
		chk(linkIsK, k);
	endtask

	// Alignment octet k of an endless run of four 32-octet multiframes
	task automatic chkIla(input int k);
		int p;
		int mf;
		p = k % 32;
		mf = (k / 32) % 4;
		if (p == 0)
			chkOct(8'h1c, 1'b1);
		else if (p == 31)
			chkOct(8'h7c, 1'b1);
		else if (mf == 1 && p == 1)
			chkOct(8'h9c, 1'b1);
		else
			chkOct(8'(p), 1'b0);
	endtask

	task automatic end_sim();
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog: the sequence needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		arst_n = 1'b0;
		testMode = link_test_pkg::MODE_NORMAL;
		linkModeIndex = 5'd14;
		variant = link_test_pkg::VAR_QUAD;
		encoding64b = 1'b0;
		convIn = '{default: 12'h000};
		linkOctetIn = 8'h00;
		linkIsKIn = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk(convOut[3], 12'h000);
		chkOct(8'h00, 1'b0);
		chk(patternActive, 12'h000);
		arst_n = 1'b1;
		repeat (8)
		begin
			step();
			chkNormal();
		end
		// Alternating data character under both encodings
		for (int e = 0; e < 2; e++)
		begin
			encoding64b = e[0];
			testMode = link_test_pkg::MODE_D215;
			repeat (6)
			begin
				step();
				chkOct(8'hb5, 1'b0);
				chk(patternActive, 12'h001);
			end
		end
		// Modes that need 8B/10B fall back to plain traffic under 64B/66B
		for (int m = 0; m < 3; m++)
		begin
			testMode = only8b[m];
			repeat (3)
			begin
				step();
				chkNormal();
			end
		end
		encoding64b = 1'b0;
		testMode = link_test_pkg::MODE_K285;
		repeat (6)
		begin
			step();
			chkOct(8'hbc, 1'b1);
		end
		testMode = link_test_pkg::MODE_NORMAL;
		step();
		testMode = link_test_pkg::MODE_RPAT;
		for (int k = 0; k < 30; k++)
		begin
			step();
			chkOct(8'(rpat[k % 12]), 1'b0);
		end
		// Transport pattern over link modes 13 to 15 and every variant
		for (int lm = 13; lm < 16; lm++)
			for (int v = 0; v < 3; v++)
			begin
				testMode = link_test_pkg::MODE_NORMAL;
				step();
				testMode = link_test_pkg::MODE_TRANSPORT;
				linkModeIndex = 5'(lm);
				variant = link_test_pkg::variant_t'(v);
				for (int s = 0; s < 4; s++)
				begin
					step();
					for (int i = 0; i < 8; i++)
						chk(convOut[i], expSample(lm, v, i, s % 2));
				end
			end
		testMode = link_test_pkg::MODE_NORMAL;
		step();
		testMode = link_test_pkg::MODE_RILA;
		step();
		chkOct(8'hbc, 1'b1);
		for (int k = 0; k < 140; k++)
		begin
			step();
			chkIla(k);
		end
		// Mid-sequence sync request restarts from code group sync
		rx.setReq(1'b0);
		// Two synchroniser edges pass with the sequence still running
		for (int k = 140; k < 142; k++)
		begin
			step();
			chkIla(k);
		end
		step();
		chkOct(8'hbc, 1'b1);
		repeat (4)
		begin
			step();
			chkOct(8'hbc, 1'b1);
		end
		rx.setReq(1'b1);
		// Release seen after two edges, then one cycle of sync remains
		repeat (3)
		begin
			step();
			chkOct(8'hbc, 1'b1);
		end
		step();
		for (int k = 0; k < 40; k++)
		begin
			chkIla(k);
			step();
		end
		// Reset in mid-run: outputs clear at once, then sync starts over
		arst_n = 1'b0;
		@(negedge clk_sys);
		chkOct(8'h00, 1'b0);
		chk(patternActive, 12'h000);
		arst_n = 1'b1;
		step();
		chkOct(8'hbc, 1'b1);
		step();
		chkIla(0);
		end_sim();
	end
endmodule
